// >>> core/scan_host_map.svh
/*
 * Address map, field positions and reset values of the processor-side port.
 * Assumes a 6-bit word address from the processor and an 11-bit memory address.
 */
`ifndef SCAN_HOST_MAP_SVH
`define SCAN_HOST_MAP_SVH

// register word addresses
`define OFF_START 6'h00
`define OFF_INT_CTRL 6'h01
`define OFF_SETUP 6'h02
`define OFF_CLK_DIV 6'h03
`define OFF_SIG_EXP 6'h04
`define OFF_SEED_LO 6'h05
`define OFF_SEED_HI 6'h06
`define OFF_STATUS 6'h07
`define OFF_INT_STATUS 6'h08
`define OFF_RESULT_LO 6'h09
`define OFF_RESULT_HI 6'h0A
`define OFF_INDEX 6'h0B
// pointer registers at PTR0 + region, memory data windows at MEM0 + region
`define OFF_PTR0 6'h10
`define OFF_MEM0 6'h20
`define REGION_COUNT 9

// memory regions
`define REG_SCAN_OUT 0
`define REG_SCAN_IN 1
`define REG_EXPECTED 2
`define REG_MASK 3

// base addresses of the four buffer address registers
`define BASE_SCAN_OUT 11'h000
`define BASE_SCAN_IN 11'h200
`define BASE_EXPECTED 11'h400
`define BASE_MASK 11'h600

// start register fields
`define START_SEQ 0
`define START_VEC_LO 1
// setup register fields
`define SETUP_TDO_DEFAULT 0
`define SETUP_TARGET_RESET 1
`define SETUP_BRIDGE 2
`define SETUP_SYNC_LO 3
`define SETUP_LOOP_LO 6
`define SETUP_BUS32 8
// status register fields
`define STAT_SEQ 4
`define STAT_VEC_LO 5
`define STAT_COMPARE 15

`define RESET_WORD 16'h0000
`define RESET_CLK_DIV 16'h0002

`endif

// >>> core/scan_host_pkg.sv
/*
 * Types shared by the processor-side port.
 * Assumes nothing beyond the map header.
 */
package scan_host_pkg;

    typedef enum logic [5:0] {
        st_idle = 6'b00_0001,
        st_read_out = 6'b00_0010,
        st_fetch = 6'b00_0100,
        st_wait = 6'b00_1000,
        st_capture = 6'b01_0000,
        st_ack_hold = 6'b10_0000
    } access_state_type;

endpackage

// >>> core/transition_finder.sv
/*
 * Edge finder for one active-low processor control line.
 * Assumes clk is the system clock; async_mode chooses the two-stage synchroniser.
 */
`timescale 1ns/1ns
module transition_finder (
    input wire logic clk,
    input wire logic nrst,
    input wire logic async_mode,
    input wire logic line_n,
    output logic fall,
    output logic rise
);

    logic sync_a;
    logic sync_b;
    logic prev;
    logic sel;

    // two stages for a line that is not timed to clk
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else begin
            sync_a <= line_n;
            sync_b <= sync_a;
        end
    end

    // synchronous bus: stages bypassed, only edges found
    assign sel = async_mode ? sync_b : line_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev <= 1'b1;
        end else begin
            prev <= sel;
        end
    end

    // one-clock pulses
    assign fall = prev & ~sel;
    assign rise = ~prev & sel;

endmodule

// >>> core/scan_master_host_port.sv
/*
 * Processor-side port of a boundary-scan test master: access state machine,
 * pointer decoder, control bank, status and interrupt unit, flag unit.
 * Assumes a dual-port memory with one cycle registered read, and the serial
 * scan side reporting its pointer moves with one-cycle enables.
 */
`timescale 1ns/1ns
`include "scan_host_map.svh"
module scan_master_host_port #(
    parameter int ADDR_W = 11,
    parameter int BUF_DEPTH = 512
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic async_mode,
    input wire logic chip_sel_n,
    input wire logic access_strobe_n,
    input wire logic read_not_write,
    input wire logic [5:0] host_addr,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    output logic host_rdata_oe,
    output logic transfer_ack,
    output logic irq,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    input wire logic [31:0] mem_rdata,
    output logic ctrl_strobe,
    output logic use_sequencer,
    output logic [2:0] use_vector,
    output logic tdo_default,
    output logic target_reset,
    output logic bridge_init,
    output logic [2:0] sync_len,
    output logic [1:0] loopback,
    output logic [15:0] clk_divisor,
    output logic [2:0] sig_exponent,
    output logic [31:0] sig_seed,
    input wire logic signature_capture_strobe,
    input wire logic [31:0] signature_value,
    input wire logic compare_result,
    input wire logic compare_load,
    input wire logic compare_clear,
    input wire logic seq_active,
    input wire logic [2:0] vec_active,
    input wire logic scan_out_taken,
    input wire logic scan_in_stored,
    output logic scan_out_empty,
    output logic scan_in_full
);

    localparam int CNT_W = $clog2(BUF_DEPTH) + 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);
    localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(BUF_DEPTH / 2);

    function automatic logic [ADDR_W-1:0] base_of(input int r);
        case (r)
            `REG_SCAN_OUT: base_of = ADDR_W'(`BASE_SCAN_OUT);
            `REG_SCAN_IN: base_of = ADDR_W'(`BASE_SCAN_IN);
            `REG_EXPECTED: base_of = ADDR_W'(`BASE_EXPECTED);
            `REG_MASK: base_of = ADDR_W'(`BASE_MASK);
            default: base_of = '0;
        endcase
    endfunction

    function automatic logic is_mem(input logic [5:0] a);
        is_mem = a >= `OFF_MEM0;
    endfunction

    function automatic logic [3:0] region_of(input logic [5:0] a);
        region_of = a[3:0];
    endfunction

    scan_host_pkg::access_state_type state;
    logic cs_fall, cs_rise, stb_fall, stb_rise;
    logic cs_active;
    logic start;
    logic [5:0] lat_addr;
    logic [31:0] lat_data;
    logic lat_rd;
    logic wr_go, rd_go;
    logic half_sel;
    logic [15:0] low_hold;
    logic [31:0] rd_cap;
    logic [15:0] start_reg, int_ctrl, setup_reg, seed_lo, seed_hi;
    logic [15:0] result_lo, result_hi;
    logic [3:0] int_status, int_pend;
    logic [3:0] flags, cond, flag_load, flag_clear, flag_event;
    logic seq_act_q, cmp_bit;
    logic [2:0] vec_act_q;
    logic [CNT_W-1:0] out_cnt, in_cnt;
    logic [ADDR_W-1:0] ptr [`REGION_COUNT];
    logic [15:0] reg_rdata;
    logic bus32, mem_commit, mem_rd_done, word_done, reading_status;
    logic start_we, setup_we, start_we_q, setup_we_q;

    transition_finder cs_edges (
        .clk(clk),
        .nrst(nrst),
        .async_mode(async_mode),
        .line_n(chip_sel_n),
        .fall(cs_fall),
        .rise(cs_rise)
    );

    transition_finder stb_edges (
        .clk(clk),
        .nrst(nrst),
        .async_mode(async_mode),
        .line_n(access_strobe_n),
        .fall(stb_fall),
        .rise(stb_rise)
    );

    assign bus32 = setup_reg[`SETUP_BUS32];
    // select may fall in the same clock as the strobe on a synchronous bus
    assign start = stb_fall & (cs_active | cs_fall);
    assign mem_commit = wr_go & is_mem(lat_addr) & (bus32 | half_sel);
    assign mem_rd_done = rd_go & is_mem(lat_addr) & (bus32 | half_sel);
    assign word_done = mem_commit | mem_rd_done;
    assign start_we = wr_go && lat_addr == `OFF_START;
    assign setup_we = wr_go && lat_addr == `OFF_SETUP;
    assign reading_status = lat_rd && lat_addr == `OFF_INT_STATUS && state != scan_host_pkg::st_idle;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_active <= 1'b0;
        end else if (cs_fall) begin
            cs_active <= 1'b1;
        end else if (cs_rise) begin
            cs_active <= 1'b0;
        end
    end

    // access state machine
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= scan_host_pkg::st_idle;
            transfer_ack <= 1'b0;
            host_rdata_oe <= 1'b0;
            host_rdata <= 32'h0000_0000;
            lat_addr <= 6'h00;
            lat_data <= 32'h0000_0000;
            lat_rd <= 1'b0;
            rd_cap <= 32'h0000_0000;
        end else begin
            case (state)
                scan_host_pkg::st_idle: begin
                    if (start) begin
                        lat_addr <= host_addr;
                        lat_data <= host_wdata;
                        lat_rd <= read_not_write;
                        if (!read_not_write) begin
                            transfer_ack <= 1'b1;
                            state <= scan_host_pkg::st_ack_hold;
                        end else if (is_mem(host_addr) && (bus32 || !half_sel)) begin
                            state <= scan_host_pkg::st_fetch;
                        end else begin
                            state <= scan_host_pkg::st_read_out;
                        end
                    end
                end
                scan_host_pkg::st_read_out: begin
                    // second half comes from the word captured by the first
                    host_rdata <= is_mem(lat_addr) ? {16'h0000, rd_cap[31:16]} : {16'h0000, reg_rdata};
                    host_rdata_oe <= 1'b1;
                    transfer_ack <= 1'b1;
                    state <= scan_host_pkg::st_ack_hold;
                end
                scan_host_pkg::st_fetch: begin
                    state <= scan_host_pkg::st_wait;
                end
                scan_host_pkg::st_wait: begin
                    state <= scan_host_pkg::st_capture;
                end
                scan_host_pkg::st_capture: begin
                    rd_cap <= mem_rdata;
                    host_rdata <= bus32 ? mem_rdata : {16'h0000, mem_rdata[15:0]};
                    host_rdata_oe <= 1'b1;
                    transfer_ack <= 1'b1;
                    state <= scan_host_pkg::st_ack_hold;
                end
                scan_host_pkg::st_ack_hold: begin
                    if (stb_rise || cs_rise) begin
                        transfer_ack <= 1'b0;
                        host_rdata_oe <= 1'b0;
                        state <= scan_host_pkg::st_idle;
                    end
                end
                default: begin
                    transfer_ack <= 1'b0;
                    host_rdata_oe <= 1'b0;
                    state <= scan_host_pkg::st_idle;
                end
            endcase
        end
    end

    // write effects run one clock after the strobe fall, from the latched cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_go <= 1'b0;
            rd_go <= 1'b0;
        end else begin
            wr_go <= state == scan_host_pkg::st_idle && start && !read_not_write;
            rd_go <= state == scan_host_pkg::st_read_out || state == scan_host_pkg::st_capture;
        end
    end

    // word joiner: half tracking for the 16-bit bus
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            half_sel <= 1'b0;
            low_hold <= 16'h0000;
        end else if (bus32) begin
            half_sel <= 1'b0;
        end else if ((wr_go || rd_go) && is_mem(lat_addr)) begin
            half_sel <= ~half_sel;
            if (wr_go && !half_sel) begin
                low_hold <= lat_data[15:0];
            end
        end else if (wr_go) begin
            // a register write in between restarts the pairing
            half_sel <= 1'b0;
        end
    end

    // memory port
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_addr <= '0;
            mem_wdata <= 32'h0000_0000;
            mem_we <= 1'b0;
            mem_re <= 1'b0;
        end else begin
            mem_we <= mem_commit;
            mem_re <= state == scan_host_pkg::st_idle && start && read_not_write && is_mem(host_addr)
                && (bus32 || !half_sel);
            if (mem_commit) begin
                mem_addr <= ptr[region_of(lat_addr)];
                mem_wdata <= bus32 ? lat_data : {lat_data[15:0], low_hold};
            end else if (state == scan_host_pkg::st_idle && start && is_mem(host_addr)) begin
                mem_addr <= ptr[region_of(host_addr)];
            end
        end
    end

    // pointer decoder
    generate
        for (genvar r = 0; r < `REGION_COUNT; r++) begin : g_ptr
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ptr[r] <= base_of(r);
                end else if (wr_go && lat_addr == 6'(`OFF_PTR0 + r)) begin
                    ptr[r] <= lat_data[ADDR_W-1:0];
                end else if (r < 4 && wr_go && lat_addr == `OFF_INDEX) begin
                    ptr[r] <= base_of(r) + lat_data[ADDR_W-1:0];
                end else if (word_done && region_of(lat_addr) == 4'(r)) begin
                    ptr[r] <= ptr[r] + 1'b1;
                end
            end
        end
    endgenerate

    // control bank
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            start_reg <= `RESET_WORD;
            int_ctrl <= `RESET_WORD;
            setup_reg <= `RESET_WORD;
            clk_divisor <= `RESET_CLK_DIV;
            sig_exponent <= 3'h0;
            seed_lo <= `RESET_WORD;
            seed_hi <= `RESET_WORD;
        end else if (wr_go) begin
            // only the low word is taken, in either bus mode
            case (lat_addr)
                `OFF_START: start_reg <= lat_data[15:0];
                `OFF_INT_CTRL: int_ctrl <= lat_data[15:0];
                `OFF_SETUP: setup_reg <= lat_data[15:0];
                `OFF_CLK_DIV: clk_divisor <= lat_data[15:0];
                `OFF_SIG_EXP: sig_exponent <= lat_data[2:0];
                `OFF_SEED_LO: seed_lo <= lat_data[15:0];
                `OFF_SEED_HI: seed_hi <= lat_data[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            start_we_q <= 1'b0;
            setup_we_q <= 1'b0;
            ctrl_strobe <= 1'b0;
        end else begin
            start_we_q <= start_we;
            setup_we_q <= setup_we;
            ctrl_strobe <= (start_we & ~start_we_q) | (setup_we & ~setup_we_q);
        end
    end

    // settings change in the same clock as the strobe, taken straight from the registers
    assign use_sequencer = start_reg[`START_SEQ];
    assign use_vector = start_reg[`START_VEC_LO +: 3];
    assign tdo_default = setup_reg[`SETUP_TDO_DEFAULT];
    assign target_reset = setup_reg[`SETUP_TARGET_RESET];
    assign bridge_init = setup_reg[`SETUP_BRIDGE];
    assign sync_len = setup_reg[`SETUP_SYNC_LO +: 3];
    assign loopback = setup_reg[`SETUP_LOOP_LO +: 2];
    assign sig_seed = {seed_hi, seed_lo};

    // status unit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result_lo <= `RESET_WORD;
            result_hi <= `RESET_WORD;
        end else if (signature_capture_strobe) begin
            result_lo <= signature_value[15:0];
            result_hi <= signature_value[31:16];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_act_q <= 1'b0;
            vec_act_q <= 3'h0;
            cmp_bit <= 1'b0;
        end else begin
            seq_act_q <= seq_active;
            vec_act_q <= vec_active;
            if (compare_clear) begin
                cmp_bit <= 1'b0;
            end else if (compare_load) begin
                cmp_bit <= compare_result;
            end
        end
    end

    // flag unit: counters follow the host and serial pointers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_cnt <= '0;
            in_cnt <= '0;
        end else begin
            // both moves in one clock cancel
            case ({mem_commit && region_of(lat_addr) == 4'(`REG_SCAN_OUT), scan_out_taken})
                2'b10: out_cnt <= (out_cnt == CNT_FULL) ? out_cnt : out_cnt + 1'b1;
                2'b01: out_cnt <= (out_cnt == '0) ? out_cnt : out_cnt - 1'b1;
                default: out_cnt <= out_cnt;
            endcase
            case ({scan_in_stored, mem_rd_done && region_of(lat_addr) == 4'(`REG_SCAN_IN)})
                2'b10: in_cnt <= (in_cnt == CNT_FULL) ? in_cnt : in_cnt + 1'b1;
                2'b01: in_cnt <= (in_cnt == '0) ? in_cnt : in_cnt - 1'b1;
                default: in_cnt <= in_cnt;
            endcase
        end
    end

    // flags: 0 scan-out empty, 1 scan-out half-empty, 2 scan-in full, 3 scan-in half-full
    assign cond = {in_cnt >= CNT_HALF, in_cnt == CNT_FULL, out_cnt <= CNT_HALF, out_cnt == '0};
    assign flag_load = cond & ~flags;
    assign flag_clear = ~cond & flags;
    assign flag_event = flag_load & int_ctrl[3:0];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags <= 4'h0;
        end else begin
            flags <= (flags | flag_load) & ~flag_clear;
        end
    end

    assign scan_out_empty = flags[0];
    assign scan_in_full = flags[2];

    // events during a status read wait in int_pend until the read ends
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            int_status <= 4'h0;
            int_pend <= 4'h0;
        end else if (reading_status) begin
            int_pend <= int_pend | flag_event;
            if (rd_go) begin
                int_status <= 4'h0;
            end
        end else begin
            int_status <= int_status | int_pend | flag_event;
            int_pend <= 4'h0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |int_status;
        end
    end

    // register read mux
    always_comb begin
        reg_rdata = 16'h0000;
        case (lat_addr)
            `OFF_START: reg_rdata = start_reg;
            `OFF_INT_CTRL: reg_rdata = int_ctrl;
            `OFF_SETUP: reg_rdata = setup_reg;
            `OFF_CLK_DIV: reg_rdata = clk_divisor;
            `OFF_SIG_EXP: reg_rdata = {13'h0000, sig_exponent};
            `OFF_SEED_LO: reg_rdata = seed_lo;
            `OFF_SEED_HI: reg_rdata = seed_hi;
            `OFF_STATUS: begin
                reg_rdata[3:0] = flags;
                reg_rdata[`STAT_SEQ] = seq_act_q;
                reg_rdata[`STAT_VEC_LO +: 3] = vec_act_q;
                reg_rdata[`STAT_COMPARE] = cmp_bit;
            end
            `OFF_INT_STATUS: reg_rdata = {12'h000, int_status};
            `OFF_RESULT_LO: reg_rdata = result_lo;
            `OFF_RESULT_HI: reg_rdata = result_hi;
            default: begin
                for (int i = 0; i < `REGION_COUNT; i++) begin
                    if (lat_addr == 6'(`OFF_PTR0 + i)) begin
                        reg_rdata = 16'(ptr[i]);
                    end
                end
            end
        endcase
    end

endmodule

// >>> verif/scan_port_sva.sv
/* pin-level assertions for the host port
   assumes a bind into scan_master_host_port */
`timescale 1ns/1ns
module scan_port_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic async_mode,
    input wire logic chip_sel_n,
    input wire logic access_strobe_n,
    input wire logic read_not_write,
    input wire logic [5:0] host_addr,
    input wire logic transfer_ack,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic ctrl_strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic go;
    // a fall only opens a cycle in a free slot
    assign go = !chip_sel_n && !transfer_ack && !async_mode;
    property p_wr; go && $fell(access_strobe_n) && !read_not_write |=> transfer_ack; endproperty
    a_wr: assert property (p_wr) else $error("write ack late");
    property p_rd; go && $fell(access_strobe_n) && read_not_write && host_addr < 6'h10
        |=> !transfer_ack ##1 transfer_ack; endproperty
    a_rd: assert property (p_rd) else $error("read ack timing");
    property p_mem; $rose(mem_re) |=> !mem_re && !transfer_ack ##1 !transfer_ack ##1 transfer_ack; endproperty
    a_mem: assert property (p_mem) else $error("fetch ack timing");
    property p_drop; !async_mode && transfer_ack && $rose(access_strobe_n) |=> !transfer_ack; endproperty
    a_drop: assert property (p_drop) else $error("ack held");
    property p_sync; async_mode && !chip_sel_n && !transfer_ack && $fell(access_strobe_n)
        |=> !transfer_ack[*2]; endproperty
    a_sync: assert property (p_sync) else $error("sync stages skipped");
    // only start (0x00) and setup (0x02) strobe; the interrupt control register sits in between
    property p_ctl; go && $fell(access_strobe_n) && !read_not_write && (host_addr == 6'h00 || host_addr == 6'h02)
        |-> ##[1:3] ctrl_strobe; endproperty
    a_ctl: assert property (p_ctl) else $error("no setup strobe");
    property p_rst; $rose(nrst) |-> !transfer_ack && !mem_re && !mem_we && !ctrl_strobe; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
    property p_we; $rose(mem_we) |-> $past(transfer_ack); endproperty
    a_we: assert property (p_we) else $error("write without access");
endmodule
bind scan_master_host_port scan_port_sva u_sva (.*);

// >>> verif/scan_mem_model.sv
/* dual-port memory, host side only
   assumes one-cycle registered read */
`timescale 1ns/1ns
module scan_mem_model (
    input wire logic clk,
    input wire logic [10:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_we,
    input wire logic mem_re,
    output logic [31:0] mem_rdata
);
    logic [31:0] m [0:2047];
    initial mem_rdata = 32'h0000_0000;
    always @(posedge clk) begin
        if (mem_we) m[mem_addr] <= mem_wdata;
        // held until the next fetch, the port samples late
        if (mem_re) mem_rdata <= m[mem_addr];
    end
endmodule

// >>> verif/scan_master_host_port_tb_top.sv
/* bench: bus driver, read monitor, memory partner
   assumes the map header and the chosen timing */
`timescale 1ns/1ns
`include "scan_host_map.svh"
module scan_master_host_port_tb_top;
    logic clk, nrst, async_mode, chip_sel_n, access_strobe_n, read_not_write, transfer_ack, irq, mem_we, mem_re;
    logic host_rdata_oe, ctrl_strobe, use_sequencer, tdo_default, target_reset, bridge_init, oe_d;
    logic seq_active, compare_result, compare_load;
    logic signature_capture_strobe, scan_out_taken, scan_in_stored, scan_out_empty, scan_in_full;
    logic [1:0] loopback;
    logic [2:0] use_vector, sync_len, vec_active, sig_exponent;
    logic [15:0] clk_divisor;
    logic [5:0] host_addr;
    logic [10:0] mem_addr;
    logic [31:0] host_wdata, host_rdata, mem_wdata, mem_rdata, signature_value, sig_seed, r, s, q[$];
    int bad_count = 0;
    int total_checks = 0;
    int k;
    scan_master_host_port u_dut (.*, .compare_clear(1'b0));
    scan_mem_model u_mem (.*);
    task automatic cmp(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic acc(input logic rd, input logic [5:0] a, input logic [31:0] d, e);
        int n;
        n = 0;
        if (rd) q.push_back(e);
        chip_sel_n <= 1'b0;
        read_not_write <= rd;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clk);
        access_strobe_n <= 1'b0;
        do @(posedge clk); while (transfer_ack !== 1'b1 && ++n < 20);
        if (transfer_ack !== 1'b1) bad_count++;
        access_strobe_n <= 1'b1;
        chip_sel_n <= 1'b1;
        do @(posedge clk); while (transfer_ack !== 1'b0 && ++n < 40);
        if (transfer_ack !== 1'b0) bad_count++;
    endtask
    // serial side: signature, scan-in stored, scan-out taken
    task sp(input logic [2:0] p);
        {signature_capture_strobe, scan_in_stored, scan_out_taken} <= p;
        @(posedge clk);
        {signature_capture_strobe, scan_in_stored, scan_out_taken} <= 3'b000;
        repeat (4) @(posedge clk);
    endtask
    always @(posedge clk) begin
        oe_d <= host_rdata_oe;
        if (host_rdata_oe === 1'b1 && oe_d !== 1'b1) begin
            if (q.size() == 0) bad_count++;
            else cmp(host_rdata, q.pop_front());
        end
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #60000;
        bad_count++;
        stop_test();
    end
    initial begin
        {nrst, async_mode, signature_capture_strobe, scan_in_stored, scan_out_taken} = 5'b00000;
        {seq_active, vec_active, compare_result, compare_load} = 6'b000000;
        {chip_sel_n, access_strobe_n, read_not_write, host_addr} = 9'h1C0;
        {host_wdata, signature_value} = 64'h0;
        r = $urandom(32'h067f_b028);
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        cmp({clk_divisor, transfer_ack, irq, scan_out_empty}, {`RESET_CLK_DIV, 3'b001});
        r = $urandom();
        s = $urandom();
        k = $urandom_range(255);
        acc(0, `OFF_SEED_LO, r, 0);
        acc(1, `OFF_SEED_LO, 0, r[15:0]);
        acc(0, `OFF_SETUP, r[7:0], 0);
        acc(0, `OFF_START, r[11:8], 0);
        cmp({use_vector, use_sequencer, loopback, sync_len, bridge_init, target_reset, tdo_default}, r[11:0]);
        acc(0, `OFF_CLK_DIV, s, 0);
        acc(0, `OFF_SIG_EXP, r, 0);
        cmp({clk_divisor, sig_exponent}, {s[15:0], r[2:0]});
        signature_value <= s;
        sp(3'b100);
        acc(1, `OFF_RESULT_LO, 0, s[15:0]);
        acc(1, `OFF_RESULT_HI, 0, s[31:16]);
        u_mem.m[`BASE_SCAN_IN + k] = s;
        acc(0, `OFF_INDEX, k, 0);
        acc(0, `OFF_MEM0, r[15:0], 0);
        acc(0, `OFF_MEM0, r[31:16], 0);
        acc(0, `OFF_MEM0, s[15:0], 0);
        acc(0, `OFF_MEM0, s[31:16], 0);
        cmp(u_mem.m[k], r);
        cmp(u_mem.m[k + 1], s);
        cmp(scan_out_empty, 1'b0);
        sp(3'b010);
        acc(1, `OFF_MEM0 + 6'h01, 0, s[15:0]);
        acc(1, `OFF_MEM0 + 6'h01, 0, s[31:16]);
        sp(3'b001);
        sp(3'b001);
        cmp(irq, 1'b0);
        {seq_active, vec_active, compare_result, compare_load} <= {1'b1, k[2:0], 2'b11};
        @(posedge clk);
        compare_load <= 1'b0;
        repeat (2) @(posedge clk);
        acc(1, `OFF_STATUS, 0, {16'h0000, 1'b1, 7'h00, k[2:0], 1'b1, 4'h3});
        acc(0, `OFF_INT_CTRL, 1, 0);
        acc(0, `OFF_MEM0, r[15:0], 0);
        acc(0, `OFF_MEM0, r[31:16], 0);
        sp(3'b001);
        cmp(irq, 1'b1);
        acc(1, `OFF_INT_STATUS, 0, 1);
        acc(1, `OFF_INT_STATUS, 0, 0);
        cmp(irq, 1'b0);
        acc(0, `OFF_SETUP, 32'h0000_0100, 0);
        acc(0, `OFF_SEED_HI, r, 0);
        acc(1, `OFF_SEED_HI, 0, r[15:0]);
        // one store per clock while held: exactly a full scan-in buffer
        scan_in_stored <= 1'b1;
        repeat (512) @(posedge clk);
        scan_in_stored <= 1'b0;
        repeat (3) @(posedge clk);
        cmp({scan_in_full, irq}, 2'b10);
        async_mode <= 1'b1;
        repeat (4) @(posedge clk);
        acc(0, `OFF_SEED_LO, s, 0);
        acc(1, `OFF_SEED_LO, 0, s[15:0]);
        cmp(sig_seed, {r[15:0], s[15:0]});
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule
